// >>> baud_rate_counter.sv
// Baud rate counter: reloadable down counter stepped twice per instruction cycle
`timescale 1ns/1ps

module baud_rate_counter
  import i2c_master_port_pkg::*;
#(
  parameter int TICK_CYCLES = `BRG_TICK_CYCLES
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic load_i, // Reload request
  input wire logic [`BAUD_RELOAD_WIDTH-1:0] reload_i, // Reload value
  output logic zero_o // Count has reached zero
);

  brg_state_type cur;
  brg_state_type next_cur;

  // Phase divider must fit its counter
  if (TICK_CYCLES < 1 || TICK_CYCLES > 16) begin : g_bad_tick
    $error("baud_rate_counter: TICK_CYCLES out of range");
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Phase marks the second and fourth clock phases
  always_comb begin
    next_cur = cur;
    if (cur.phase == 4'(TICK_CYCLES - 1)) begin
      next_cur.phase = 4'h0;
    end else begin
      next_cur.phase = cur.phase + 4'h1;
    end
    if (load_i) begin
      next_cur.count = reload_i; // RULE11
      next_cur.phase = 4'h0;
    end else if (cur.phase == 4'(TICK_CYCLES - 1) && cur.count != '0) begin
      next_cur.count = cur.count - 7'h01; // RULE18
    end
    next_cur.zero = (next_cur.count == '0) && !load_i; // RULE17
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign zero_o = cur.zero;

endmodule // baud_rate_counter

// >>> i2c_master_port.sv
// I2C master port: bus monitor, arbitration, command sequencer and receive buffer
//
// Notes on behaviour
// RULE1 - Reset or disable clears start and stop seen
// RULE2 - Bus free after stop, or neither seen
// RULE3 - Interrupt flag on start, stop, byte, ack
// RULE4 - Stop seen on busy bus raises interrupt
// RULE5 - Mismatch of driven and sampled SDA flags collision
// RULE6 - Master only with master mode and enable
// RULE7 - One operation at a time; busy write collides
// RULE8 - Master makes every SCL pulse, start, stop
// RULE9 - Transmit: address with write bit, data, ack
// RULE10 - Receive: address with read bit, ack driven
// RULE11 - Reload from low seven bits, starts on write
// RULE12 - Clock stops after operation, SCL holds level
// RULE13 - Start enable makes start, flag, hold time
// RULE14 - Slave acknowledge captured into status bit six
// RULE15 - Flag at end of ninth SCL cycle
// RULE16 - Stop enable makes stop, flag when done
// RULE17 - Counter runs to zero then stops
// RULE18 - Counter steps on second and fourth phases
// RULE19 - Reload waits while slave stretches SCL
// RULE20 - Reload value selects standard, fast, 1 MHz
// RULE21 - Lines only pulled low or released
`timescale 1ns/1ps

module i2c_master_port
  import i2c_master_port_pkg::*;
#(
  parameter int BRG_TICK = `BRG_TICK_CYCLES
) (
  input wire logic core_clk_i, // Core clock, 20 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic port_enable_bit_i, // Port enable
  input wire logic [`PORT_MODE_WIDTH-1:0] port_mode_field_i, // Port mode select
  input wire logic [`BYTE_WIDTH-1:0] baud_reload_register_i, // Baud reload value
  input wire logic start_enable_bit_i, // Start request pulse
  input wire logic restart_enable_i, // Repeated start request pulse
  input wire logic stop_enable_bit_i, // Stop request pulse
  input wire logic receive_enable_i, // Receive one byte request pulse
  input wire logic ack_enable_i, // Send acknowledge request pulse
  input wire logic ack_data_i, // Acknowledge level to send, 0 = ack
  input wire logic shift_buffer_write_i, // Shift buffer write strobe
  input wire logic [`BYTE_WIDTH-1:0] shift_buffer_i, // Shift buffer write data
  input wire logic irq_enable_i, // Serial interrupt enable
  input wire logic irq_flag_clear_i, // Clear serial_irq_flag
  input wire logic bus_collision_clear_i, // Clear bus_collision_flag
  input wire logic write_collision_clear_i, // Clear write_collision_bit
  input wire logic rx_ready_i, // Receiver takes rx_data_o
  input wire logic sda_i, // SDA line level
  input wire logic scl_i, // SCL line level
  output logic sda_o, // SDA output level, always low
  output logic sda_oe_o, // SDA pulled low while high
  output logic scl_o, // SCL output level, always low
  output logic scl_oe_o, // SCL pulled low while high
  output logic serial_irq_flag_o, // Sticky serial interrupt flag
  output logic irq_o, // Serial interrupt request
  output logic bus_collision_flag_o, // Sticky arbitration loss flag
  output logic write_collision_bit_o, // Sticky discarded write flag
  output logic ack_status_o, // Last acknowledge from slave
  output logic start_seen_o, // Start seen last on bus
  output logic stop_seen_o, // Stop seen last on bus
  output logic bus_free_o, // Bus may be taken
  output logic busy_o, // Operation in progress
  output logic [`BYTE_WIDTH-1:0] rx_data_o, // Received byte at buffer head
  output logic rx_valid_o // Buffer head holds a byte
);

  core_state_type cur;
  core_state_type next_cur;
  logic brg_load;
  logic brg_zero;

  // ****************************************************************
  // Baud rate counter
  // ****************************************************************
  // Reload value and BRG_TICK set the SCL rate
  baud_rate_counter #(
    .TICK_CYCLES(BRG_TICK)
  ) i_baud_rate_counter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(brg_load),
    .reload_i(baud_reload_register_i[`BAUD_RELOAD_WIDTH-1:0]), // RULE11 RULE20
    .zero_o(brg_zero)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic active;
    logic start_evt;
    logic stop_evt;
    logic set_irq;
    logic set_bcol;
    logic set_write_collision_bit;
    logic pop;
    logic push;
    logic [`BYTE_WIDTH-1:0] shifted;
    logic last_bit;
    active = 1'b0;
    start_evt = 1'b0;
    stop_evt = 1'b0;
    set_irq = 1'b0;
    set_bcol = 1'b0;
    set_write_collision_bit = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    shifted = '0;
    last_bit = 1'b0;
    next_cur = cur;
    brg_load = 1'b0;

    // Master mode gate
    active = port_enable_bit_i && (port_mode_field_i == `PORT_MODE_MASTER); // RULE6

    // Bus condition detector
    start_evt = cur.prev_scl && scl_i && cur.prev_sda && !sda_i;
    stop_evt = cur.prev_scl && scl_i && !cur.prev_sda && sda_i;
    next_cur.prev_sda = sda_i;
    next_cur.prev_scl = scl_i;
    if (!port_enable_bit_i) begin
      next_cur.start_seen = 1'b0; // RULE1
      next_cur.stop_seen = 1'b0; // RULE1
    end else if (start_evt) begin
      next_cur.start_seen = 1'b1;
      next_cur.stop_seen = 1'b0;
    end else if (stop_evt) begin
      next_cur.start_seen = 1'b0;
      next_cur.stop_seen = 1'b1;
    end
    next_cur.bus_free = next_cur.stop_seen ||
                        (!next_cur.start_seen && !next_cur.stop_seen); // RULE2

    // Conditions made by another master while this one is idle
    if (active && cur.st == ST_IDLE && (start_evt || stop_evt)) begin
      set_irq = 1'b1; // RULE3 RULE4
    end

    // Receive buffer drain
    pop = cur.vld0 && rx_ready_i;
    if (pop) begin
      next_cur.ent0 = cur.ent1;
      next_cur.vld0 = cur.vld1;
      next_cur.vld1 = 1'b0;
    end

    if (receive_enable_i) begin
      next_cur.rcv_pend = 1'b1;
    end

    // Command sequencer
    case (cur.st)
      ST_IDLE: begin
        if (shift_buffer_write_i && (start_enable_bit_i || restart_enable_i ||
            stop_enable_bit_i)) begin
          set_write_collision_bit = 1'b1; // RULE7
        end
        if (!active) begin
          next_cur.sda_oe = 1'b0;
          next_cur.scl_oe = 1'b0;
          next_cur.rcv_pend = 1'b0;
        end else if (start_enable_bit_i) begin
          if (!cur.bus_free || !sda_i || !scl_i) begin
            set_bcol = 1'b1; // RULE5
          end else begin
            next_cur.sda_oe = 1'b0;
            next_cur.scl_oe = 1'b0;
            brg_load = 1'b1;
            next_cur.st = ST_START_CHECK; // RULE13
          end
        end else if (restart_enable_i) begin
          next_cur.sda_oe = 1'b0;
          brg_load = 1'b1;
          next_cur.st = ST_RSTART_LOW;
        end else if (stop_enable_bit_i) begin
          next_cur.sda_oe = 1'b1;
          brg_load = 1'b1;
          next_cur.st = ST_STOP_LOW; // RULE16
        end else if (shift_buffer_write_i) begin
          // First byte carries address and direction bit
          next_cur.shreg = shift_buffer_i; // RULE9 RULE10
          next_cur.bitcnt = `RESET_COUNT;
          next_cur.rx_mode = 1'b0;
          next_cur.sda_oe = !shift_buffer_i[`BYTE_WIDTH-1];
          brg_load = 1'b1; // RULE11
          next_cur.st = ST_BIT_LOW;
        end else if ((cur.rcv_pend || receive_enable_i) && !cur.vld1) begin
          // Receive starts only with a free buffer entry
          next_cur.rcv_pend = 1'b0;
          next_cur.bitcnt = `RESET_COUNT;
          next_cur.rx_mode = 1'b1;
          next_cur.sda_oe = 1'b0;
          brg_load = 1'b1;
          next_cur.st = ST_BIT_LOW; // RULE10
        end else if (ack_enable_i) begin
          next_cur.sda_oe = !ack_data_i; // RULE10
          brg_load = 1'b1;
          next_cur.st = ST_ACK_LOW;
        end
      end

      ST_START_CHECK: begin
        if (!scl_i) begin
          set_bcol = 1'b1; // RULE5
        end else if (!sda_i || brg_zero) begin
          // Another master pulled SDA: assert early
          next_cur.sda_oe = 1'b1;
          brg_load = 1'b1;
          next_cur.st = ST_START_HOLD;
        end
      end

      ST_START_HOLD: begin
        if (brg_zero) begin
          next_cur.scl_oe = 1'b1; // RULE8
          set_irq = 1'b1; // RULE3 RULE13
          next_cur.st = ST_IDLE;
        end
      end

      ST_RSTART_LOW: begin
        if (brg_zero) begin
          next_cur.scl_oe = 1'b0;
          brg_load = 1'b1;
          next_cur.st = ST_RSTART_HIGH;
        end
      end

      ST_RSTART_HIGH: begin
        if (!scl_i) begin
          brg_load = 1'b1; // RULE19
        end else if (!sda_i) begin
          set_bcol = 1'b1; // RULE5
        end else if (brg_zero) begin
          // Bus stays held into the next transfer
          next_cur.sda_oe = 1'b1; // RULE8
          brg_load = 1'b1;
          next_cur.st = ST_START_HOLD;
        end
      end

      ST_BIT_LOW: begin
        if (brg_zero) begin
          next_cur.scl_oe = 1'b0; // RULE8 RULE21
          brg_load = 1'b1;
          next_cur.st = ST_BIT_HIGH;
        end
      end

      ST_BIT_HIGH: begin
        last_bit = cur.rx_mode ? (cur.bitcnt == `LAST_RX_BIT) : (cur.bitcnt == `LAST_TX_BIT);
        shifted = {cur.shreg[`BYTE_WIDTH-2:0], cur.rx_mode ? sda_i : 1'b0};
        if (!scl_i) begin
          brg_load = 1'b1; // RULE19
        end else if (!cur.rx_mode && cur.bitcnt != `LAST_TX_BIT &&
                     !cur.sda_oe && !sda_i) begin
          set_bcol = 1'b1; // RULE5 RULE21
        end else if (brg_zero) begin
          next_cur.scl_oe = 1'b1;
          next_cur.bitcnt = cur.bitcnt + 4'h1;
          if (cur.rx_mode || cur.bitcnt != `LAST_TX_BIT) begin
            next_cur.shreg = shifted;
          end else begin
            next_cur.ack_stat = sda_i; // RULE9 RULE14
          end
          if (last_bit) begin
            // Clock stops, SCL held low
            set_irq = 1'b1; // RULE3 RULE12 RULE15
            push = cur.rx_mode;
            next_cur.sda_oe = 1'b0;
            next_cur.st = ST_IDLE;
          end else begin
            // Next data bit, or release SDA for the slave acknowledge
            next_cur.sda_oe = !cur.rx_mode && (cur.bitcnt != `LAST_RX_BIT) &&
                              !shifted[`BYTE_WIDTH-1];
            brg_load = 1'b1;
            next_cur.st = ST_BIT_LOW;
          end
        end
      end

      ST_ACK_LOW: begin
        if (brg_zero) begin
          next_cur.scl_oe = 1'b0;
          brg_load = 1'b1;
          next_cur.st = ST_ACK_HIGH;
        end
      end

      ST_ACK_HIGH: begin
        if (!scl_i) begin
          brg_load = 1'b1; // RULE19
        end else if (!cur.sda_oe && !sda_i) begin
          set_bcol = 1'b1; // RULE5
        end else if (brg_zero) begin
          next_cur.scl_oe = 1'b1;
          set_irq = 1'b1; // RULE3 RULE12
          next_cur.st = ST_IDLE;
        end
      end

      ST_STOP_LOW: begin
        if (brg_zero) begin
          next_cur.scl_oe = 1'b0;
          brg_load = 1'b1;
          next_cur.st = ST_STOP_HIGH;
        end
      end

      ST_STOP_HIGH: begin
        if (!scl_i) begin
          brg_load = 1'b1; // RULE19
        end else if (brg_zero) begin
          next_cur.sda_oe = 1'b0; // RULE8
          brg_load = 1'b1;
          next_cur.st = ST_STOP_HOLD;
        end
      end

      ST_STOP_HOLD: begin
        if (brg_zero) begin
          set_irq = 1'b1; // RULE16
          next_cur.st = ST_IDLE;
        end
      end

      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase

    // Any write while an operation runs is discarded
    if (cur.st != ST_IDLE && shift_buffer_write_i) begin
      set_write_collision_bit = 1'b1; // RULE7
    end

    // Arbitration loss releases both lines
    if (set_bcol) begin
      next_cur.sda_oe = 1'b0;
      next_cur.scl_oe = 1'b0;
      next_cur.st = ST_IDLE;
    end

    // Disable forces the sequencer home
    if (!active) begin
      next_cur.st = ST_IDLE;
      next_cur.sda_oe = 1'b0;
      next_cur.scl_oe = 1'b0;
      push = 1'b0;
    end

    // Receive buffer fill
    if (push) begin
      if (!next_cur.vld0) begin
        next_cur.ent0 = shifted;
        next_cur.vld0 = 1'b1;
      end else begin
        next_cur.ent1 = shifted;
        next_cur.vld1 = 1'b1;
      end
    end

    // Sticky flags, set wins over clear
    next_cur.irq_flag = (cur.irq_flag && !irq_flag_clear_i) || set_irq; // RULE3
    next_cur.bcol = (cur.bcol && !bus_collision_clear_i) || set_bcol; // RULE5
    next_cur.write_collision_bit = (cur.write_collision_bit && !write_collision_clear_i) || set_write_collision_bit; // RULE7
    next_cur.irq = next_cur.irq_flag && irq_enable_i; // RULE4
    next_cur.busy = (next_cur.st != ST_IDLE);
    next_cur.active = active;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0; // RULE1
      cur.st <= ST_IDLE;
      cur.prev_sda <= 1'b1;
      cur.prev_scl <= 1'b1;
      cur.bus_free <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Pins are only ever pulled low
  assign sda_o = 1'b0; // RULE21
  assign scl_o = 1'b0; // RULE21
  assign sda_oe_o = cur.sda_oe;
  assign scl_oe_o = cur.scl_oe;
  assign serial_irq_flag_o = cur.irq_flag;
  assign irq_o = cur.irq;
  assign bus_collision_flag_o = cur.bcol;
  assign write_collision_bit_o = cur.write_collision_bit;
  assign ack_status_o = cur.ack_stat;
  assign start_seen_o = cur.start_seen;
  assign stop_seen_o = cur.stop_seen;
  assign bus_free_o = cur.bus_free;
  assign busy_o = cur.busy;
  assign rx_data_o = cur.ent0;
  assign rx_valid_o = cur.vld0;

endmodule // i2c_master_port

// >>> i2c_master_port_chk.sv
// Assertion checker of the I2C master port
`timescale 1ns/1ps
`include "i2c_master_port_map.svh"
module i2c_master_port_chk (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic port_enable_bit_i, // Enable
  input wire logic [`PORT_MODE_WIDTH-1:0] port_mode_field_i, // Mode
  input wire logic start_enable_bit_i, // Start
  input wire logic shift_buffer_write_i, // Write
  input wire logic irq_enable_i, // Irq enable
  input wire logic rx_ready_i, // Rx taken
  input wire logic sda_i, // SDA
  input wire logic scl_i, // SCL
  input wire logic sda_oe_o, // SDA low
  input wire logic scl_oe_o, // SCL low
  input wire logic serial_irq_flag_o, // Flag
  input wire logic irq_o, // Irq
  input wire logic bus_collision_flag_o, // Lost
  input wire logic write_collision_bit_o, // Dropped
  input wire logic start_seen_o, // Start seen
  input wire logic stop_seen_o, // Stop seen
  input wire logic bus_free_o, // Free
  input wire logic busy_o, // Busy
  input wire logic [`BYTE_WIDTH-1:0] rx_data_o, // Rx byte
  input wire logic rx_valid_o // Rx valid
);
  logic master;

  // Master operation allowed
  assign master = port_enable_bit_i && port_mode_field_i == `PORT_MODE_MASTER;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // **********
  // Properties
  // **********
  AST_OFF_CLR: assert property (
    !port_enable_bit_i |=> !start_seen_o && !stop_seen_o) else $error("seen bits kept");
  AST_FREE: assert property (
    $stable({start_seen_o, stop_seen_o}) |-> bus_free_o == (stop_seen_o || !start_seen_o))
    else $error("bus free wrong");
  AST_IRQ: assert property (
    (irq_enable_i && serial_irq_flag_o) [*2] |-> irq_o) else $error("irq missing");
  AST_LOST: assert property (
    $rose(bus_collision_flag_o) |=> !sda_oe_o && !scl_oe_o && !busy_o) else $error("lines kept");
  AST_MODE: assert property (
    !master [*2] |-> !sda_oe_o && !scl_oe_o) else $error("drives when off");
  AST_WRITE_COLLISION_BIT: assert property (
    shift_buffer_write_i && busy_o |=> write_collision_bit_o) else $error("write kept");
  AST_GO: assert property (
    start_enable_bit_i && !busy_o && master && bus_free_o && sda_i && scl_i |=> busy_o)
    else $error("start ignored");
  AST_DONE: assert property (
    $fell(busy_o) && !bus_collision_flag_o && port_enable_bit_i |-> serial_irq_flag_o)
    else $error("no flag");
  AST_HOLD: assert property (
    !busy_o && !$past(busy_o) && port_enable_bit_i && $past(port_enable_bit_i)
    |-> $stable(scl_oe_o)) else $error("scl moved");
  AST_RX: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o)) else $error("rx lost");
endmodule // i2c_master_port_chk

bind i2c_master_port i2c_master_port_chk i_chk (.*);

// >>> i2c_master_port_map.svh
// Field widths and values, reset values and timing counts of the I2C master port
`ifndef I2C_MASTER_PORT_MAP_SVH
`define I2C_MASTER_PORT_MAP_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CORE_CLK_PERIOD_NS 50
`define INSTR_CYCLE_NS 200
// Two counter decrements per instruction cycle
`define BRG_DECS_PER_INSTR 2
`define BRG_TICK_CYCLES ((`INSTR_CYCLE_NS / `CORE_CLK_PERIOD_NS) / `BRG_DECS_PER_INSTR)

// ****************************************************************
// Field widths and values
// ****************************************************************
`define BAUD_RELOAD_WIDTH 7
`define PORT_MODE_WIDTH 4
`define PORT_MODE_MASTER 4'h8
`define BYTE_WIDTH 8
`define BIT_COUNT_WIDTH 4
`define LAST_TX_BIT 4'h8
`define LAST_RX_BIT 4'h7
`define ACK_STATUS_BIT 6

// ****************************************************************
// Reset values
// ****************************************************************
`define RESET_BYTE 8'h00
`define RESET_COUNT 4'h0

`endif

// >>> i2c_master_port_pkg.sv
// Types shared by the I2C master port design files
`include "i2c_master_port_map.svh"

package i2c_master_port_pkg;

  // ****************************************************************
  // Master sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_CHECK,
    ST_START_HOLD,
    ST_RSTART_LOW,
    ST_RSTART_HIGH,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_ACK_LOW,
    ST_ACK_HIGH,
    ST_STOP_LOW,
    ST_STOP_HIGH,
    ST_STOP_HOLD
  } master_state_type;

  // ****************************************************************
  // Register state of the baud rate counter
  // ****************************************************************
  typedef struct packed {
    logic [`BAUD_RELOAD_WIDTH-1:0] count;
    logic [3:0] phase;
    logic zero;
  } brg_state_type;

  // ****************************************************************
  // Register state of the master core
  // ****************************************************************
  typedef struct packed {
    master_state_type st;
    logic [`BYTE_WIDTH-1:0] shreg;
    logic [`BIT_COUNT_WIDTH-1:0] bitcnt;
    logic rx_mode;
    logic rcv_pend;
    logic sda_oe;
    logic scl_oe;
    logic prev_sda;
    logic prev_scl;
    logic start_seen;
    logic stop_seen;
    logic bus_free;
    logic irq_flag;
    logic irq;
    logic bcol;
    logic write_collision_bit;
    logic ack_stat;
    logic busy;
    logic active;
    logic [`BYTE_WIDTH-1:0] ent0;
    logic [`BYTE_WIDTH-1:0] ent1;
    logic vld0;
    logic vld1;
  } core_state_type;

endpackage

// >>> i2c_slave_model.sv
// I2C slave model with optional clock stretching
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a // Own address
) (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic sda_i, // SDA wire
  input wire logic scl_i, // SCL wire
  input wire logic stretch_i, // Stretch SCL
  input wire logic [7:0] tx_i, // Byte to send
  output logic sda_oe_o, // Pull SDA low
  output logic scl_oe_o, // Pull SCL low
  output logic [7:0] rx_o // Byte taken
);
  logic ps, pc, on, adr, rd, hit;
  logic [3:0] cnt, hold;
  logic [7:0] sh, dsh;

  // Address match and clock stretch
  assign hit = sh[7:1] == ADDR;
  assign scl_oe_o = hold != 4'h0;

  // Bus watcher and byte engine
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {ps, pc} <= 2'h3;
      {on, adr, rd, sda_oe_o, cnt, hold, sh, dsh, rx_o} <= '0;
    end else begin
      ps <= sda_i;
      pc <= scl_i;
      hold <= (hold != 4'h0) ? hold - 4'h1 : 4'h0;
      if (scl_i && pc && ps && !sda_i) begin
        {on, adr, cnt, sda_oe_o} <= {2'h3, 4'hf, 1'b0}; // Start, SCL fall wraps count
      end else if (scl_i && pc && !ps && sda_i) begin
        {on, sda_oe_o} <= 2'h0; // Stop
      end else if (on && scl_i && !pc) begin
        sh <= {sh[6:0], sda_i};
      end else if (on && !scl_i && pc) begin
        hold <= stretch_i ? 4'hf : 4'h0;
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h7 && adr) begin
          {on, rd, sda_oe_o} <= {hit, hit && sh[0], hit};
        end else if (cnt == 4'h7) begin
          {rx_o, sda_oe_o} <= {sh, !rd};
        end else if (cnt == 4'h8) begin
          adr <= 1'b0;
          rd <= rd && (adr || !sh[0]);
          dsh <= tx_i;
          sda_oe_o <= rd && (adr || !sh[0]) && !tx_i[7];
        end else begin
          dsh <= {dsh[6:0], 1'b0};
          sda_oe_o <= rd && !adr && !dsh[6];
        end
      end
    end
  end
endmodule // i2c_slave_model

// >>> test_i2c_master_port.sv
// Self-checking testbench of the I2C master port
`timescale 1ns/1ps
`include "i2c_master_port_map.svh"
module test_i2c_master_port;
  localparam logic [6:0] SLV = 7'h2a;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en = 1'b1, stretch = 1'b0, ext_sda = 1'b0, rdy = 1'b0, ie = 1'b0;
  logic [3:0] mode = `PORT_MODE_MASTER;
  logic [5:0] cmd = '0; // Start, restart, stop, write, receive, ack
  logic [2:0] clr = '0;
  logic [7:0] wd = '0, tx = '0, rxd, srx;
  logic msda, mscl, ssda, sscl, sda, scl, flag, irq, bcol, write_collision_bit, ack, sst, spp, free, busy, rxv;
  int bad_count = 0, compares = 0, n;

  // Pulled-up wires
  assign sda = !(msda || ssda || ext_sda);
  assign scl = !(mscl || sscl);

  // Clock
  always #25 core_clk_i = !core_clk_i;

  i2c_master_port i_i2c_master_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .port_enable_bit_i(en), .port_mode_field_i(mode), .baud_reload_register_i(8'h83),
    .start_enable_bit_i(cmd[0]), .restart_enable_i(cmd[1]), .stop_enable_bit_i(cmd[2]),
    .shift_buffer_write_i(cmd[3]), .receive_enable_i(cmd[4]), .ack_enable_i(cmd[5]),
    .ack_data_i(wd[0]), .shift_buffer_i(wd), .irq_enable_i(ie), .irq_flag_clear_i(clr[0]),
    .bus_collision_clear_i(clr[1]), .write_collision_clear_i(clr[2]), .rx_ready_i(rdy),
    .sda_i(sda), .scl_i(scl), .sda_o(), .sda_oe_o(msda), .scl_o(), .scl_oe_o(mscl),
    .serial_irq_flag_o(flag), .irq_o(irq), .bus_collision_flag_o(bcol),
    .write_collision_bit_o(write_collision_bit), .ack_status_o(ack), .start_seen_o(sst), .stop_seen_o(spp),
    .bus_free_o(free), .busy_o(busy), .rx_data_o(rxd), .rx_valid_o(rxv));

  i2c_slave_model #(.ADDR(SLV)) i_i2c_slave_model (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sda_i(sda), .scl_i(scl), .stretch_i(stretch), .tx_i(tx), .sda_oe_o(ssda),
    .scl_oe_o(sscl), .rx_o(srx));

  // **********
  // Helpers
  // **********
  task chk8(input logic [7:0] a, input logic [7:0] e, input string m);
    compares++;
    if (a !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task chkb(input logic a, input logic e, input string m);
    chk8({7'h0, a}, {7'h0, e}, m);
  endtask
  task op(input logic [5:0] c, input logic [7:0] d, input logic [5:0] c2 = '0);
    @(negedge core_clk_i);
    cmd = c;
    wd = d;
    @(negedge core_clk_i);
    cmd = c2;
    @(negedge core_clk_i);
    cmd = '0;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge core_clk_i);
      n++;
    end
    chkb(n < 4000, 1'b1, "hang");
  endtask
  task clear();
    @(negedge core_clk_i);
    clr = 3'h7;
    @(negedge core_clk_i);
    clr = '0;
  endtask
  task done();
    chkb(flag, 1'b1, "no flag");
    clear();
  endtask

  // **********
  // Scenarios
  // **********
  task t_write();
    op(6'h01, 8'h00);
    done();
    chkb(n < 40, 1'b1, "slow start");
    chkb(free, 1'b0, "free");
    op(6'h08, {SLV, 1'b0});
    done();
    chkb(ack, 1'b0, "addr ack");
    op(6'h08, 8'ha5);
    done();
    chk8(srx, 8'ha5, "data");
    chkb(mscl, 1'b1, "scl kept");
    op(6'h04, 8'h00);
    done();
    chkb(spp & free, 1'b1, "stop");
    $display("write test done");
  endtask
  task t_read();
    op(6'h01, 8'h00);
    done();
    op(6'h08, {~SLV, 1'b0});
    done();
    chkb(ack, 1'b1, "nack");
    op(6'h02, 8'h00);
    done();
    stretch = 1'b1;
    tx = 8'h3c;
    op(6'h08, {SLV, 1'b1});
    done();
    op(6'h10, 8'h00);
    done();
    tx = 8'hc3;
    op(6'h20, 8'h00);
    done();
    op(6'h10, 8'h00);
    done();
    chk8(rxd, 8'h3c, "head");
    op(6'h20, 8'h01);
    done();
    stretch = 1'b0;
    op(6'h04, 8'h00);
    done();
    rdy = 1'b1;
    @(negedge core_clk_i);
    chk8(rxd, 8'hc3, "second");
    @(negedge core_clk_i);
    chkb(rxv, 1'b0, "drained");
    rdy = 1'b0;
    $display("read test done");
  endtask
  task t_coll();
    op(6'h09, 8'h00);
    chkb(write_collision_bit, 1'b1, "write kept");
    chkb(irq, 1'b0, "irq off");
    done();
    ext_sda = 1'b1;
    op(6'h08, 8'hff, 6'h08);
    chkb(bcol & write_collision_bit, 1'b1, "no loss");
    chkb(msda | mscl, 1'b0, "held");
    clear();
    ie = 1'b1;
    ext_sda = 1'b0;
    repeat (6) @(negedge core_clk_i);
    chkb(irq & spp & free, 1'b1, "no stop irq");
    clear();
    $display("collision test done");
  endtask
  task t_off();
    mode = 4'h0;
    op(6'h01, 8'h00);
    chkb(msda | flag, 1'b0, "not master");
    mode = `PORT_MODE_MASTER;
    en = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chkb(spp, 1'b0, "seen kept");
    en = 1'b1;
    op(6'h01, 8'h00);
    done();
    op(6'h04, 8'h00);
    done();
    $display("enable test done");
  endtask

  // Verdict
  task end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #2000000;
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge core_clk_i);
    rst_i = 1'b0;
    chkb(free, 1'b1, "reset free");
    chkb(sst | spp, 1'b0, "reset seen");
    t_write();
    t_read();
    t_coll();
    t_off();
    end_of_test();
  end
endmodule // test_i2c_master_port
